// [pkg/ifd_regs.svh]
// Purpose: Offsets, field positions, reset values and counts of the decoder
// Assumes: Byte addressed 32-bit register port
// Notes:   Definitions only
`ifndef IFD_REGS_SVH
`define IFD_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define IFD_OFS_CTRL      8'h00
`define IFD_OFS_BANK      8'h04
`define IFD_OFS_STATUS    8'h08
`define IFD_OFS_CYCLES    8'h0C
`define IFD_OFS_PC        8'h10
`define IFD_OFS_TABPTR    8'h14

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define IFD_CTRL_RUN_BIT  0
`define IFD_CTRL_RST      1'h1
`define IFD_BANK_W        6
`define IFD_BANK_RST      6'h00
`define IFD_PC_RST        21'h000000
`define IFD_TP_RST        21'h000000
`define IFD_ST_FIRST_BIT  0
`define IFD_ST_WORD2_BIT  1
`define IFD_ST_WORD3_BIT  2
`define IFD_ST_SKIP_BIT   3
`define IFD_ST_PEND_BIT   4

// ----------------------------------------------------------------------------
// Decode and timing constants
// ----------------------------------------------------------------------------
`define IFD_Q_PER_CYC     4
`define IFD_TAIL_MARK     4'hF
`define IFD_ACC_SPLIT     8'h60
`define IFD_ACC_HI_BANK   6'h3F
`define IFD_PC_STEP       21'h000002

`endif

// [pkg/ifd_pkg.sv]
// Purpose: Types shared by the decoder files
// Assumes: Nothing
// Notes:   Enumerations carry no explicit codes
package ifd_pkg;

    typedef enum logic [2:0] {
        IFD_CL_BYTE,
        IFD_CL_BIT,
        IFD_CL_LIT,
        IFD_CL_CTL,
        IFD_CL_TAIL
    } ifd_class_t;

    typedef enum logic [1:0] {
        IFD_ST_FIRST,
        IFD_ST_WORD2,
        IFD_ST_WORD3,
        IFD_ST_SKIP
    } ifd_state_t;

endpackage

// [pkg/ifd_phase_if.sv]
// Purpose: Carries the oscillator phase of the instruction cycle
// Assumes: One clock domain
// Notes:   Driven by the phase counter, read by the decoder
`timescale 1ns/1ns
interface ifd_phase_if;
    logic [1:0] phase;
    logic       cyc_end;

    modport src (output phase, output cyc_end);
    modport snk (input phase, input cyc_end);
endinterface

// [logic/ifd_phase.sv]
// Purpose: Divides the clock into instruction cycles
// Assumes: clk_en freezes the count
// Notes:   cyc_end marks the last oscillator period of a cycle
`timescale 1ns/1ns
`include "ifd_regs.svh"
module ifd_phase #(
    parameter int QN = `IFD_Q_PER_CYC
) (
    input  wire logic  ref_clk,
    input  wire logic  rst_n,
    input  wire logic  clk_en,
    ifd_phase_if.src   ph
);
    logic [1:0] q_r;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            q_r <= 2'h0;
        end else if (clk_en) begin
            q_r <= (q_r == 2'(QN - 1)) ? 2'h0 : q_r + 2'h1;
        end
    end

    assign ph.phase   = q_r;
    assign ph.cyc_end = (q_r == 2'(QN - 1));
endmodule

// [logic/ifd_core.sv]
// Purpose: Instruction word decoder and execution timing sequencer
// Assumes: Program memory returns pm_data for pm_addr within the cycle
// Notes:   Datapath answers dp_cond_true during the cycle after ex_valid
`timescale 1ns/1ns
`include "ifd_regs.svh"

module ifd_core (
    input  wire logic                ref_clk,
    input  wire logic                rst_n,
    input  wire logic                clk_en,
    input  wire logic [7:0]          reg_addr,
    input  wire logic [31:0]         reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic [31:0]              reg_rdata,
    output logic [20:0]              pm_addr,
    input  wire logic [15:0]         pm_data,
    input  wire logic                dp_cond_true,
    input  wire logic [20:0]         dp_redirect_pc,
    output logic                     ex_valid,
    output logic                     ex_nop,
    output ifd_pkg::ifd_class_t      ex_class,
    output logic [15:0]              ex_word,
    output logic [13:0]              ex_file_addr,
    output logic                     ex_dest_file,
    output logic [2:0]               ex_bit,
    output logic [19:0]              ex_literal,
    output logic [1:0]               ex_ptr_sel,
    output logic                     ex_shadow_save,
    output logic                     ex_shadow_restore,
    output logic                     ex_tbl_active,
    output logic [1:0]               ex_tbl_mode,
    output logic [20:0]              ex_tbl_addr
);
    import ifd_pkg::*;

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    ifd_phase_if ph ();

    ifd_state_t  state_r;
    ifd_class_t  cls_r;
    ifd_class_t  dec_cls;
    ifd_class_t  e_cls;
    logic [1:0]  nw_r;
    logic [1:0]  dec_nw;
    logic [1:0]  skip_cnt_r;
    logic [15:0] w1_r;
    logic [15:0] w2_r;
    logic [15:0] src1;
    logic [15:0] src2;
    logic [20:0] pc_r;
    logic [20:0] pc_inc;
    logic        run_r;
    logic [5:0]  bank_r;
    logic [31:0] cyc_r;
    logic [20:0] tp_r;
    logic        pend_r;
    logic        pend_ctl_r;
    logic        pend_jmp_r;
    logic [20:0] pend_tgt_r;
    logic        bnd;
    logic        kill;
    logic        skip;
    logic        emit;
    logic        e_jmp;
    logic        e_tbl;
    logic [20:0] e_tgt;
    logic [7:0]  e_f;
    logic [13:0] e_addr;

    ifd_phase #(
        .QN      (`IFD_Q_PER_CYC)
    ) u_phase (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .ph      (ph.src)
    );

    // ------------------------------------------------------------------------
    // Instruction cycle boundary
    // ------------------------------------------------------------------------
    assign bnd    = clk_en & ph.cyc_end & run_r;
    assign pc_inc = pc_r + `IFD_PC_STEP;
    // Outcome of the instruction issued at the previous boundary
    assign kill   = pend_r & (pend_jmp_r | (pend_ctl_r & dp_cond_true));
    assign skip   = pend_r & ~pend_ctl_r & dp_cond_true;

    // ------------------------------------------------------------------------
    // First word class and length
    // ------------------------------------------------------------------------
    always_comb begin
        dec_cls = IFD_CL_BYTE;
        dec_nw  = 2'h1;
        case (pm_data[15:12])
            4'h0: begin
                if (pm_data[11:8] == 4'h0) begin
                    if (pm_data[7:4] == 4'h6 || pm_data[7:0] == 8'h02) begin
                        dec_nw = 2'h3;
                    end else begin
                        dec_cls = IFD_CL_CTL;
                    end
                end else if (pm_data[11:8] == 4'h1 || pm_data[11]) begin
                    dec_cls = IFD_CL_LIT;
                end
            end
            4'h7, 4'h8, 4'h9, 4'hA, 4'hB: begin
                dec_cls = IFD_CL_BIT;
            end
            4'hC: begin
                dec_nw = 2'h2;
            end
            4'hD: begin
                dec_cls = IFD_CL_CTL;
            end
            4'hE: begin
                if (!pm_data[11]) begin
                    dec_cls = IFD_CL_CTL;
                end else if (pm_data[11:8] == 4'hB) begin
                    dec_nw = 2'h2;
                end else if (pm_data[11:8] == 4'hE) begin
                    dec_cls = IFD_CL_LIT;
                    dec_nw  = 2'h2;
                end else if (pm_data[11:8] >= 4'hC) begin
                    dec_cls = IFD_CL_CTL;
                    dec_nw  = 2'h2;
                end else begin
                    dec_cls = IFD_CL_LIT;
                end
            end
            `IFD_TAIL_MARK: begin
                dec_cls = IFD_CL_TAIL;
            end
            default: begin
                dec_cls = IFD_CL_BYTE;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Operand fields of the completing instruction
    // ------------------------------------------------------------------------
    assign src1  = (state_r == IFD_ST_FIRST) ? pm_data : w1_r;
    assign src2  = (state_r == IFD_ST_WORD2) ? pm_data : w2_r;
    assign e_cls = (state_r == IFD_ST_FIRST) ? dec_cls : cls_r;
    assign e_jmp = (src1[15:9] == 7'b1110110) || (src1[15:8] == 8'hEF);
    assign e_tgt = {src2[11:0], src1[7:0], 1'b0};
    assign e_tbl = (src1[15:4] == 12'h000) && src1[3];
    assign e_f   = src1[7:0];

    always_comb begin
        e_addr = {bank_r, e_f};
        if (!src1[8]) begin
            e_addr = (e_f < `IFD_ACC_SPLIT) ? {6'h00, e_f} : {`IFD_ACC_HI_BANK, e_f};
        end
    end

    always_comb begin
        emit = 1'b0;
        if (bnd) begin
            case (state_r)
                IFD_ST_FIRST: begin
                    emit = ~kill & ~skip & (dec_cls != IFD_CL_TAIL) & (dec_nw == 2'h1);
                end
                IFD_ST_WORD2: begin
                    emit = (nw_r == 2'h2);
                end
                IFD_ST_WORD3: begin
                    emit = 1'b1;
                end
                default: begin
                    emit = 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Sequencer: word consumption and program counter
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r    <= IFD_ST_FIRST;
            pc_r       <= `IFD_PC_RST;
            w1_r       <= 16'h0000;
            w2_r       <= 16'h0000;
            cls_r      <= IFD_CL_BYTE;
            nw_r       <= 2'h1;
            skip_cnt_r <= 2'h0;
        end else if (bnd) begin
            case (state_r)
                IFD_ST_FIRST: begin
                    if (kill) begin
                        // Fetched word discarded, cycle runs as no-op
                        pc_r <= pend_jmp_r ? pend_tgt_r : dp_redirect_pc;
                    end else if (skip) begin
                        pc_r <= pc_inc;
                        if (dec_nw > 2'h1) begin
                            state_r    <= IFD_ST_SKIP;
                            skip_cnt_r <= dec_nw - 2'h1;
                        end
                    end else begin
                        pc_r  <= pc_inc;
                        w1_r  <= pm_data;
                        cls_r <= dec_cls;
                        nw_r  <= dec_nw;
                        if (dec_cls != IFD_CL_TAIL && dec_nw > 2'h1) begin
                            state_r <= IFD_ST_WORD2;
                        end
                    end
                end
                IFD_ST_WORD2: begin
                    pc_r    <= pc_inc;
                    w2_r    <= pm_data;
                    state_r <= (nw_r == 2'h3) ? IFD_ST_WORD3 : IFD_ST_FIRST;
                end
                IFD_ST_WORD3: begin
                    pc_r    <= pc_inc;
                    state_r <= IFD_ST_FIRST;
                end
                IFD_ST_SKIP: begin
                    pc_r       <= pc_inc;
                    skip_cnt_r <= skip_cnt_r - 2'h1;
                    if (skip_cnt_r == 2'h1) begin
                        state_r <= IFD_ST_FIRST;
                    end
                end
                default: begin
                    state_r <= IFD_ST_FIRST;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Pending outcome of the issued instruction
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_r     <= 1'b0;
            pend_ctl_r <= 1'b0;
            pend_jmp_r <= 1'b0;
            pend_tgt_r <= `IFD_PC_RST;
        end else if (bnd) begin
            pend_r     <= emit;
            pend_ctl_r <= emit & (e_cls == IFD_CL_CTL);
            pend_jmp_r <= emit & (e_cls == IFD_CL_CTL) & e_jmp;
            pend_tgt_r <= e_tgt;
        end
    end

    // ------------------------------------------------------------------------
    // Execution outputs
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ex_valid          <= 1'b0;
            ex_nop            <= 1'b0;
            ex_class          <= IFD_CL_BYTE;
            ex_word           <= 16'h0000;
            ex_file_addr      <= 14'h0000;
            ex_dest_file      <= 1'b0;
            ex_bit            <= 3'h0;
            ex_literal        <= 20'h00000;
            ex_ptr_sel        <= 2'h0;
            ex_shadow_save    <= 1'b0;
            ex_shadow_restore <= 1'b0;
            ex_tbl_active     <= 1'b0;
            ex_tbl_mode       <= 2'h0;
        end else if (clk_en) begin
            // Every boundary outside a word fetch reports a cycle
            ex_valid <= emit | (bnd & (state_r != IFD_ST_WORD2 || nw_r == 2'h2)
                                     & (state_r != IFD_ST_WORD3 || 1'b0)
                                     & ~(state_r == IFD_ST_FIRST & ~kill & ~skip
                                         & dec_cls != IFD_CL_TAIL & dec_nw > 2'h1));
            ex_nop   <= ~emit;
            if (emit) begin
                ex_class          <= e_cls;
                ex_word           <= src1;
                ex_file_addr      <= e_addr;
                ex_dest_file      <= (e_cls == IFD_CL_BYTE) & src1[9];
                ex_bit            <= (e_cls == IFD_CL_BIT) ? src1[11:9] : 3'h0;
                ex_ptr_sel        <= (src1[15:8] == 8'hEE) ? src1[5:4] : 2'h0;
                ex_literal        <= (src1[15:8] == 8'hEE) ?
                                     {8'h00, src1[3:0], src2[7:0]} :
                                     (e_jmp ? e_tgt[20:1] : {12'h000, e_f});
                ex_shadow_save    <= (src1[15:8] == 8'hED);
                ex_shadow_restore <= (src1 == 16'h0011) || (src1 == 16'h0013);
                ex_tbl_active     <= e_tbl;
                ex_tbl_mode       <= e_tbl ? src1[1:0] : 2'h0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Table pointer
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tp_r        <= `IFD_TP_RST;
            ex_tbl_addr <= `IFD_TP_RST;
        end else if (clk_en) begin
            if (emit && e_tbl) begin
                ex_tbl_addr <= (src1[1:0] == 2'h3) ? tp_r + 21'h1 : tp_r;
                case (src1[1:0])
                    2'h1, 2'h3: tp_r <= tp_r + 21'h1;
                    2'h2:       tp_r <= tp_r - 21'h1;
                    default:    tp_r <= tp_r;
                endcase
            end else if (reg_wr && reg_addr == `IFD_OFS_TABPTR) begin
                tp_r <= reg_wdata[20:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_r  <= `IFD_CTRL_RST;
            bank_r <= `IFD_BANK_RST;
        end else if (clk_en && reg_wr) begin
            if (reg_addr == `IFD_OFS_CTRL) begin
                run_r <= reg_wdata[`IFD_CTRL_RUN_BIT];
            end
            if (reg_addr == `IFD_OFS_BANK) begin
                bank_r <= reg_wdata[`IFD_BANK_W-1:0];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cyc_r <= 32'h00000000;
        end else if (bnd) begin
            cyc_r <= cyc_r + 32'h00000001;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h00000000;
        end else if (clk_en) begin
            reg_rdata <= 32'h00000000;
            if (reg_rd) begin
                case (reg_addr)
                    `IFD_OFS_CTRL:   reg_rdata <= {31'h0, run_r};
                    `IFD_OFS_BANK:   reg_rdata <= {26'h0, bank_r};
                    `IFD_OFS_STATUS: reg_rdata <= {27'h0, pend_r,
                                                   state_r == IFD_ST_SKIP,
                                                   state_r == IFD_ST_WORD3,
                                                   state_r == IFD_ST_WORD2,
                                                   state_r == IFD_ST_FIRST};
                    `IFD_OFS_CYCLES: reg_rdata <= cyc_r;
                    `IFD_OFS_PC:     reg_rdata <= {11'h0, pc_r};
                    `IFD_OFS_TABPTR: reg_rdata <= {11'h0, tp_r};
                    default:         reg_rdata <= 32'h00000000;
                endcase
            end
        end
    end

    assign pm_addr = pc_r;
endmodule

// [dv/ifd_pmem.sv]
// Purpose: Program memory model feeding instruction words
// Assumes: Combinational read of the addressed word
// Notes:   Testbench loads the words before reset ends
`timescale 1ns/1ns
module ifd_pmem (
    input  wire logic [20:0] pm_addr,
    output logic      [15:0] pm_data
);
    logic [15:0] mem [0:63];

    initial begin
        for (int i = 0; i < 64; i++) mem[i] = 16'h0000;
    end

    // Byte address, bit 0 ignored
    assign pm_data = mem[pm_addr[6:1]];
endmodule

// [dv/ifd_core_sva.sv]
// Purpose: Port checks of the decoder
// Assumes: One clock domain
// Notes:   Bound to ifd_core
`timescale 1ns/1ns
module ifd_core_sva (
    input wire logic                ref_clk,
    input wire logic                rst_n,
    input wire logic                clk_en,
    input wire logic [20:0]         pm_addr,
    input wire logic                ex_valid,
    input wire logic                ex_nop,
    input wire ifd_pkg::ifd_class_t ex_class,
    input wire logic [15:0]         ex_word,
    input wire logic [13:0]         ex_file_addr,
    input wire logic                ex_dest_file,
    input wire logic [2:0]          ex_bit,
    input wire logic                ex_shadow_save,
    input wire logic                ex_shadow_restore,
    input wire logic                ex_tbl_active,
    input wire logic [1:0]          ex_tbl_mode
);
    import ifd_pkg::*;
    logic iss;
    logic dfa;
    assign iss = ex_valid && !ex_nop;
    // Byte ops with d and a fields
    assign dfa = iss && (ex_word[15:12] inside {4'h2, 4'h3, 4'h4, 4'h5});
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_valid_spacing: assert property (ex_valid && clk_en |=> !ex_valid [*3])
        else $error("ex_valid pulses closer than one cycle");
    a_pc_step: assert property ($changed(pm_addr) && ex_class != IFD_CL_CTL
        |-> pm_addr == $past(pm_addr) + 21'h000002)
        else $error("pm_addr did not step by one word");
    a_pc_hold: assert property ($changed(pm_addr) |=> $stable(pm_addr) [*3])
        else $error("pm_addr moved inside an instruction cycle");
    a_tail_silent: assert property (iss |-> ex_word[15:12] != 4'hF)
        else $error("tail word issued as instruction");
    a_dest_select: assert property (dfa |-> ex_dest_file == ex_word[9])
        else $error("destination select wrong");
    a_access_ram: assert property (dfa && !ex_word[8]
        |-> ex_file_addr == {(ex_word[7:0] < 8'h60) ? 6'h00 : 6'h3F, ex_word[7:0]})
        else $error("access RAM address wrong");
    a_bit_number: assert property (iss && ex_class == IFD_CL_BIT
        |-> ex_bit == ex_word[11:9])
        else $error("bit number wrong");
    a_fast_call: assert property (iss && ex_word[15:9] == 7'h76
        |-> ex_shadow_save == ex_word[8])
        else $error("shadow save wrong on call");
    a_fast_return: assert property (iss && ex_word[15:2] == 14'h0004
        |-> ex_shadow_restore == ex_word[0])
        else $error("shadow restore wrong on return");
    a_table_mode: assert property (iss && ex_word[15:3] == 13'h0001
        |-> ex_tbl_active && ex_tbl_mode == ex_word[1:0])
        else $error("table mode wrong");
endmodule

bind ifd_core ifd_core_sva chk (
    .ref_clk, .rst_n, .clk_en, .pm_addr, .ex_valid, .ex_nop, .ex_class, .ex_word,
    .ex_file_addr, .ex_dest_file, .ex_bit, .ex_shadow_save, .ex_shadow_restore,
    .ex_tbl_active, .ex_tbl_mode
);

// [dv/instruction_format_timing_tb.sv]
// Purpose: Runs a fixed program through the decoder
// Assumes: clk_en held high, fixed redirect target
// Notes:   Each test task waits for its issue pulses in order
`timescale 1ns/1ns
module instruction_format_timing_tb;
    import ifd_pkg::*;
    logic        ref_clk, rst_n, clk_en, reg_wr, reg_rd, dp_cond_true;
    logic        ex_valid, ex_nop, ex_dest_file, ex_shadow_save, ex_shadow_restore;
    logic        ex_tbl_active;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd;
    logic [20:0] pm_addr, dp_redirect_pc, ex_tbl_addr;
    logic [15:0] pm_data, ex_word;
    logic [13:0] ex_file_addr;
    logic [2:0]  ex_bit;
    logic [19:0] ex_literal;
    logic [1:0]  ex_ptr_sel, ex_tbl_mode;
    ifd_class_t  ex_class;
    int          error_cnt, total_checks, cyc, last_cyc;
    logic [15:0] prog [0:22] = '{16'h2A15, 16'h2470, 16'h2500, 16'h8A22, 16'h0E5A,
        16'hEE1A, 16'hF0BC, 16'hF123, 16'hA000, 16'hEE00, 16'hF011, 16'h0009, 16'h000B,
        16'h000A, 16'h0008, 16'hED14, 16'hF000, 16'h0E99, 16'h0000, 16'h0000, 16'h0013,
        16'h0E77, 16'h0012};

    ifd_core uut (
        .ref_clk, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .pm_addr, .pm_data, .dp_cond_true, .dp_redirect_pc, .ex_valid, .ex_nop,
        .ex_class, .ex_word, .ex_file_addr, .ex_dest_file, .ex_bit, .ex_literal,
        .ex_ptr_sel, .ex_shadow_save, .ex_shadow_restore, .ex_tbl_active, .ex_tbl_mode,
        .ex_tbl_addr
    );
    ifd_pmem pm (.pm_addr(pm_addr), .pm_data(pm_data));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // Datapath flag: test-bit skips, fast return redirects
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (ex_valid === 1'b1) begin
            dp_cond_true <= !ex_nop && (ex_word == 16'hA000 || ex_word == 16'h0013);
        end
        if (cyc == 3000) begin
            error_cnt = error_cnt + 1;
            results();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // Waits for the next issue pulse and checks its kind and spacing
    task automatic issue(input logic nop, input logic [15:0] w, input int gap);
        int n;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (ex_valid !== 1'b1 && n < 40);
        check("ex_valid", ex_valid, 1'b1);
        if (gap != 0) check("issue gap", cyc - last_cyc, gap);
        last_cyc = cyc;
        check("ex_nop", ex_nop, nop);
        if (!nop) check("ex_word", ex_word, w);
    endtask

    task automatic reg_access(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr    <= wr;
        reg_rd    <= !wr;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b0;
        @(negedge ref_clk);
        rd = reg_rdata;
    endtask

    task automatic t_byte_ops;
        issue(1'b0, 16'h2A15, 0);
        check("class", ex_class, IFD_CL_BYTE);
        check("file", ex_file_addr, 14'h0015);
        check("dest", ex_dest_file, 1'b1);
        issue(1'b0, 16'h2470, 4);
        check("file", ex_file_addr, 14'h3F70);
        check("dest", ex_dest_file, 1'b0);
        issue(1'b0, 16'h2500, 4);
        check("file", ex_file_addr, 14'h0500);
        $display("t_byte_ops done");
    endtask

    task automatic t_bit_lit;
        issue(1'b0, 16'h8A22, 4);
        check("class", ex_class, IFD_CL_BIT);
        check("bit", ex_bit, 3'h5);
        check("file", ex_file_addr, 14'h0022);
        issue(1'b0, 16'h0E5A, 4);
        check("class", ex_class, IFD_CL_LIT);
        check("literal", ex_literal, 20'h0005A);
        $display("t_bit_lit done");
    endtask

    task automatic t_two_word_tail;
        issue(1'b0, 16'hEE1A, 8);
        check("ptr sel", ex_ptr_sel, 2'h1);
        check("literal", ex_literal, 20'h00ABC);
        issue(1'b1, 16'h0000, 4);
        check("held word", ex_word, 16'hEE1A);
        $display("t_two_word_tail done");
    endtask

    task automatic t_skip;
        issue(1'b0, 16'hA000, 4);
        issue(1'b1, 16'h0000, 4);
        issue(1'b1, 16'h0000, 4);
        check("held word", ex_word, 16'hA000);
        $display("t_skip done");
    endtask

    task automatic t_table;
        logic [15:0] w [4] = '{16'h0009, 16'h000B, 16'h000A, 16'h0008};
        logic [1:0]  m [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
        logic [20:0] p [4] = '{21'h000000, 21'h000002, 21'h000002, 21'h000001};
        for (int i = 0; i < 4; i++) begin
            issue(1'b0, w[i], 4);
            check("tbl active", ex_tbl_active, 1'b1);
            check("tbl mode", ex_tbl_mode, m[i]);
            check("tbl addr", ex_tbl_addr, p[i]);
        end
        $display("t_table done");
    endtask

    task automatic t_call;
        issue(1'b0, 16'hED14, 8);
        check("class", ex_class, IFD_CL_CTL);
        check("shadow save", ex_shadow_save, 1'b1);
        check("target", ex_literal, 20'h00014);
        issue(1'b1, 16'h0000, 4);
        issue(1'b0, 16'h0013, 4);
        check("shadow restore", ex_shadow_restore, 1'b1);
        check("pc", pm_addr, 21'h00002A);
        issue(1'b1, 16'h0000, 4);
        issue(1'b0, 16'h0012, 4);
        check("shadow restore", ex_shadow_restore, 1'b0);
        check("pc", pm_addr, 21'h00002E);
        $display("t_call done");
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        {rst_n, reg_wr, reg_rd, dp_cond_true} = 4'h0;
        clk_en = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h00000000;
        dp_redirect_pc = 21'h00002C;
        {error_cnt, total_checks, cyc, last_cyc} = {4{32'h00000000}};
        repeat (2) @(posedge ref_clk);
        for (int i = 0; i < 23; i++) pm.mem[i] = prog[i];
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        reg_access(1'b1, 8'h04, 32'h00000005);
        t_byte_ops();
        t_bit_lit();
        t_two_word_tail();
        t_skip();
        t_table();
        t_call();
        reg_access(1'b0, 8'h04, 32'h00000000);
        check("bank", rd, 32'h00000005);
        reg_access(1'b0, 8'h40, 32'h00000000);
        check("unmapped", rd, 32'h00000000);
        $display("t_regs done");
        results();
    end
endmodule
